// ### rtl/mraf_core.sv
// memory reference address sequencer and operand packer with axi4-lite access
// How it works
// - double word at n, n+1, msw first
// - double: high to upper, low to lower
// - float48 is 32 mantissa, sign, 15 exponent
// - float48 mantissa normalized, zero all clear
// - float48 memory: exponent, high, low mantissa
// - float48 lower, upper, exponent register split
// - float32: 23 mantissa, sign, 8 exponent
// - float32 zero all clear, else normalized
// - float32 two words, exponent word first
// - float32 in upper and lower only
// - opcode 15-11, x 10, i 9, b 8
// - displacement sign extended, -128 to +127
// - jump, byte, block forms excluded
// - pre-index b replaces p before indirection
// - post-index x after indirection or after b, else base
// - three bits choose eight address forms
// - all clear means p plus displacement
// - only indirection adds one memory read
// - indirect word is full 16-bit address
// - sixteen bit words, bit 15 msb
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "mraf_defines.svh"
module mraf_core (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // main memory read port, same clock
  output logic             mem_rd_req,
  output logic [15:0]      mem_rd_addr,
  input  wire logic        mem_rd_ack,
  input  wire logic [15:0] mem_rd_data
);
  // software visible registers and sequencer internals
  logic [15:0] instr_reg;           // instruction word under decode
  logic [15:0] p_reg;               // program counter value
  logic [15:0] b_reg;               // base register
  logic [15:0] x_reg;               // index register
  logic [1:0]  fmt_reg;             // operand format
  logic        excl_reg;            // instruction uses its own form
  logic [15:0] ea_reg;              // effective address result
  logic [15:0] upper_reg;           // upper accumulator image
  logic [15:0] lower_reg;           // lower accumulator image
  logic [15:0] exp_reg;             // exponent register image
  logic        done_reg;            // sticky completion flag
  logic        excl_flag_reg;       // last start was refused
  logic [1:0]  rdcnt_reg;           // operand words read so far
  logic [1:0]  indcnt_reg;          // indirect reads taken
  logic [15:0] ptr_reg;             // fetched indirect pointer
  logic [15:0] word_reg [0:2];      // operand words as read
  mraf_pkg::mraf_state_t state_reg; // sequencer state
  mraf_pkg::mraf_memreq_t req_reg;  // outstanding memory read
  // bus side holding registers
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        start;
  // address former outputs
  mraf_pkg::mraf_instr_t fields;
  logic [15:0] first_addr;
  logic [15:0] final_direct;
  logic [15:0] final_indir;
  logic [15:0] oper_ea;

  // number of words an operand format spans
  function automatic logic [1:0] fmt_words(input logic [1:0] f);
    case (f)
      `MRAF_FMT_DOUBLE: fmt_words = 2'h2;
      `MRAF_FMT_FLT48:  fmt_words = 2'h3;
      `MRAF_FMT_FLT32:  fmt_words = 2'h2;
      default:          fmt_words = 2'h1;
    endcase
  endfunction

  // merge of a 16-bit field under two byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  mraf_ea_calc u_ea (
    .instr        (instr_reg),
    .p_val        (p_reg),
    .b_val        (b_reg),
    .x_val        (x_reg),
    .ptr_val      (ptr_reg),
    .fields       (fields),
    .first_addr   (first_addr),
    .final_direct (final_direct),
    .final_indir  (final_indir)
  );

  // effective address: pointer path only when indirect
  assign oper_ea = fields.indir ? final_indir : final_direct;

  // write channel capture, address and data in either order
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
  assign wr_fire       = aw_got_reg && w_got_reg && !s_axi_bvalid;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_got_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_got_reg <= 1'b0;
    end
  end

  // write response, okay up to the x register address, slverr above it
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MRAF_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg <= `MRAF_ADDR_XREG) ? `MRAF_RESP_OKAY : `MRAF_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // start only from idle; writes while busy still land
  assign start = wr_fire && (awaddr_reg == `MRAF_ADDR_CTRL) && wstrb_reg[0]
                 && wdata_reg[`MRAF_CTRL_START] && (state_reg == mraf_pkg::ST_IDLE);

  // writable registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      instr_reg <= 16'h0000;
      p_reg     <= 16'h0000;
      b_reg     <= 16'h0000;
      x_reg     <= 16'h0000;
      fmt_reg   <= `MRAF_FMT_WORD;
      excl_reg  <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (awaddr_reg)
        `MRAF_ADDR_CTRL:
        begin
          if (wstrb_reg[0])
          begin
            fmt_reg  <= wdata_reg[`MRAF_CTRL_FMT_HI:`MRAF_CTRL_FMT_LO];
            excl_reg <= wdata_reg[`MRAF_CTRL_EXCL];
          end
        end
        `MRAF_ADDR_INSTR: instr_reg <= merge16(instr_reg, wdata_reg, wstrb_reg);
        `MRAF_ADDR_PREG:  p_reg     <= merge16(p_reg, wdata_reg, wstrb_reg);
        `MRAF_ADDR_BREG:  b_reg     <= merge16(b_reg, wdata_reg, wstrb_reg);
        `MRAF_ADDR_XREG:  x_reg     <= merge16(x_reg, wdata_reg, wstrb_reg);
        default:          excl_reg  <= excl_reg;
      endcase
    end
  end

  // address sequencer: indirection costs exactly one read
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg     <= mraf_pkg::ST_IDLE;
      req_reg       <= '0;
      ea_reg        <= 16'h0000;
      ptr_reg       <= 16'h0000;
      rdcnt_reg     <= 2'h0;
      indcnt_reg    <= 2'h0;
      excl_flag_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        mraf_pkg::ST_IDLE:
        begin
          // refusal follows the bit written together with start; excl_reg only lands at this same edge
          if (start && wdata_reg[`MRAF_CTRL_EXCL])
            excl_flag_reg <= 1'b1;
          else if (start)
          begin
            excl_flag_reg <= 1'b0;
            indcnt_reg    <= 2'h0;
            rdcnt_reg     <= 2'h0;
            state_reg     <= mraf_pkg::ST_CALC;
          end
        end
        mraf_pkg::ST_CALC:
        begin
          if (fields.indir)
          begin
            req_reg   <= '{valid: 1'b1, addr: first_addr};
            state_reg <= mraf_pkg::ST_INDIR;
          end
          else
          begin
            ea_reg    <= final_direct;
            req_reg   <= '{valid: 1'b1, addr: final_direct};
            state_reg <= mraf_pkg::ST_OPER;
          end
        end
        mraf_pkg::ST_INDIR:
        begin
          if (mem_rd_ack)
          begin
            ptr_reg    <= mem_rd_data;
            indcnt_reg <= 2'h1;
            req_reg    <= '0;
            state_reg  <= mraf_pkg::ST_CALC;
          end
        end
        mraf_pkg::ST_OPER:
        begin
          if (fields.indir && indcnt_reg != 2'h0 && !req_reg.valid)
          begin
            ea_reg  <= oper_ea;
            req_reg <= '{valid: 1'b1, addr: oper_ea};
          end
          else if (mem_rd_ack)
          begin
            rdcnt_reg <= 2'(rdcnt_reg + 2'h1);
            if (2'(rdcnt_reg + 2'h1) == fmt_words(fmt_reg))
            begin
              req_reg   <= '0;
              state_reg <= mraf_pkg::ST_DONE;
            end
            else
              req_reg.addr <= 16'(req_reg.addr + 16'h0001);
          end
        end
        mraf_pkg::ST_DONE:
          state_reg <= mraf_pkg::ST_IDLE;
        default:
          state_reg <= mraf_pkg::ST_IDLE;
      endcase
      // after the pointer returns, go straight to the operand read
      if (state_reg == mraf_pkg::ST_CALC && indcnt_reg != 2'h0)
      begin
        req_reg   <= '0;
        state_reg <= mraf_pkg::ST_OPER;
      end
    end
  end

  // capture operand words in address order
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      word_reg[0] <= 16'h0000;
      word_reg[1] <= 16'h0000;
      word_reg[2] <= 16'h0000;
    end
    else if (state_reg == mraf_pkg::ST_OPER && req_reg.valid && mem_rd_ack)
      word_reg[rdcnt_reg] <= mem_rd_data;
  end

  // unpack into accumulator images once all words are in
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      upper_reg <= 16'h0000;
      lower_reg <= 16'h0000;
      exp_reg   <= 16'h0000;
    end
    else if (state_reg == mraf_pkg::ST_DONE)
    begin
      case (fmt_reg)
        `MRAF_FMT_DOUBLE:
        begin
          upper_reg <= word_reg[0];
          lower_reg <= word_reg[1];
        end
        `MRAF_FMT_FLT48:
        begin
          // all-zero stays all-zero; stored mantissa already normalized
          exp_reg   <= word_reg[0];
          upper_reg <= word_reg[1];
          lower_reg <= word_reg[2];
        end
        `MRAF_FMT_FLT32:
        begin
          // hidden leading one stays packed; exponent register kept
          upper_reg <= word_reg[0];
          lower_reg <= word_reg[1];
        end
        default:
          upper_reg <= word_reg[0];
      endcase
    end
  end

  // sticky done: a new start clears it, completion sets it
  always_ff @(posedge clk)
  begin
    if (srst)
      done_reg <= 1'b0;
    else if (state_reg == mraf_pkg::ST_DONE)
      done_reg <= 1'b1;
    else if (start)
      done_reg <= 1'b0;
  end

  // memory port straight from the request register
  assign mem_rd_req  = req_reg.valid;
  assign mem_rd_addr = req_reg.addr;

  // read channel, one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MRAF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `MRAF_RESP_OKAY;
      case (s_axi_araddr)
        `MRAF_ADDR_CTRL:   s_axi_rdata <= {28'h0, excl_reg, fmt_reg, 1'b0};
        `MRAF_ADDR_INSTR:  s_axi_rdata <= {16'h0, instr_reg};
        `MRAF_ADDR_PREG:   s_axi_rdata <= {16'h0, p_reg};
        `MRAF_ADDR_BREG:   s_axi_rdata <= {16'h0, b_reg};
        `MRAF_ADDR_XREG:   s_axi_rdata <= {16'h0, x_reg};
        `MRAF_ADDR_STATUS: s_axi_rdata <= {26'h0, rdcnt_reg, 1'b0, excl_flag_reg, done_reg,
                                           state_reg != mraf_pkg::ST_IDLE};
        `MRAF_ADDR_EA:     s_axi_rdata <= {16'h0, ea_reg};
        `MRAF_ADDR_UPPER:  s_axi_rdata <= {16'h0, upper_reg};
        `MRAF_ADDR_LOWER:  s_axi_rdata <= {16'h0, lower_reg};
        `MRAF_ADDR_EXPREG: s_axi_rdata <= {16'h0, exp_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `MRAF_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // direct modes never touch memory before the operand read
  a_direct_no_indir: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_CALC && !fields.indir) |=> state_reg == mraf_pkg::ST_OPER)
    else $error("direct mode took an extra step");
  // plain relative form
  a_p_relative: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_CALC && instr_reg[10:8] == 3'b000) |=> ea_reg == 16'($past(p_reg) + $past(fields.disp)))
    else $error("p relative address wrong");
  // base relative before indirection
  a_b_first_read: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_CALC && fields.indir && fields.pre_b && indcnt_reg == 2'h0)
    |=> mem_rd_addr == 16'($past(b_reg) + $past(fields.disp)))
    else $error("pre-index not applied before indirection");
  // index relative direct
  a_x_relative: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_CALC && instr_reg[10:8] == 3'b100) |=> ea_reg == 16'($past(x_reg) + $past(fields.disp)))
    else $error("x relative address wrong");
  // displacement sign extension
  a_disp_sext: assert property (@(posedge clk) disable iff (srst)
    fields.disp[15:8] == {8{instr_reg[7]}})
    else $error("displacement not sign extended");
  // refused start leaves sequencer idle
  a_excl_idle: assert property (@(posedge clk) disable iff (srst)
    (start && wdata_reg[`MRAF_CTRL_EXCL]) |=> state_reg == mraf_pkg::ST_IDLE && excl_flag_reg)
    else $error("excluded instruction was sequenced");
  // indirect read returns to calc then operand
  sequence s_ptr_back;
    state_reg == mraf_pkg::ST_INDIR && mem_rd_ack;
  endsequence
  a_indir_once: assert property (@(posedge clk) disable iff (srst)
    s_ptr_back |=> state_reg == mraf_pkg::ST_CALC ##1 state_reg == mraf_pkg::ST_OPER)
    else $error("indirection not exactly one read");
  // double word unpack
  a_double_split: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_DONE && fmt_reg == `MRAF_FMT_DOUBLE)
    |=> upper_reg == $past(word_reg[0]) && lower_reg == $past(word_reg[1]))
    else $error("double word halves misplaced");
  // float32 keeps exponent register
  a_f32_exp_kept: assert property (@(posedge clk) disable iff (srst)
    (state_reg == mraf_pkg::ST_DONE && fmt_reg == `MRAF_FMT_FLT32) |=> $stable(exp_reg))
    else $error("float32 touched exponent register");
endmodule

// ### rtl/mraf_defines.svh
// constants for the memory reference address and operand format block
`ifndef MRAF_DEFINES_SVH
`define MRAF_DEFINES_SVH
`define MRAF_OP_HI        4'hf
`define MRAF_OP_LO        4'hb
`define MRAF_XBIT         4'ha
`define MRAF_IBIT         4'h9
`define MRAF_BBIT         4'h8
`define MRAF_DISP_HI      4'h7
`define MRAF_ADDR_CTRL    32'h0000_0000
`define MRAF_ADDR_INSTR   32'h0000_0004
`define MRAF_ADDR_PREG    32'h0000_0008
`define MRAF_ADDR_BREG    32'h0000_000c
`define MRAF_ADDR_XREG    32'h0000_0010
`define MRAF_ADDR_STATUS  32'h0000_0014
`define MRAF_ADDR_EA      32'h0000_0018
`define MRAF_ADDR_UPPER   32'h0000_001c
`define MRAF_ADDR_LOWER   32'h0000_0020
`define MRAF_ADDR_EXPREG  32'h0000_0024
`define MRAF_CTRL_START   5'h00
`define MRAF_CTRL_FMT_LO  5'h01
`define MRAF_CTRL_FMT_HI  5'h02
`define MRAF_CTRL_EXCL    5'h03
`define MRAF_ST_BUSY      5'h00
`define MRAF_ST_DONE      5'h01
`define MRAF_ST_EXCL      5'h02
`define MRAF_ST_RDCNT_LO  5'h04
`define MRAF_ST_RDCNT_HI  5'h05
`define MRAF_RESP_OKAY    2'h0
`define MRAF_RESP_SLVERR  2'h2
`define MRAF_FMT_WORD     2'h0
`define MRAF_FMT_DOUBLE   2'h1
`define MRAF_FMT_FLT48    2'h2
`define MRAF_FMT_FLT32    2'h3
`endif

// ### rtl/mraf_pkg.sv
// types shared by the memory reference address and operand format block
package mraf_pkg;
  // decoded fields of one memory reference instruction word
  typedef struct packed {
    logic [4:0]  opcode;
    logic        post_x;
    logic        indir;
    logic        pre_b;
    logic [15:0] disp;
  } mraf_instr_t;
  // one main memory read request
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } mraf_memreq_t;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CALC  = 3'b001,
    ST_INDIR = 3'b010,
    ST_OPER  = 3'b011,
    ST_DONE  = 3'b100
  } mraf_state_t;
endpackage

// ### rtl/mraf_ea_calc.sv
// combinational effective address former for the eight mode forms
`timescale 1ns/1ps
`include "mraf_defines.svh"
module mraf_ea_calc (
  // instruction and registers
  input  wire logic [15:0]        instr,
  input  wire logic [15:0]        p_val,
  input  wire logic [15:0]        b_val,
  input  wire logic [15:0]        x_val,
  // fetched pointer for indirect modes
  input  wire logic [15:0]        ptr_val,
  // results
  output mraf_pkg::mraf_instr_t   fields,
  output logic      [15:0]        first_addr,
  output logic      [15:0]        final_direct,
  output logic      [15:0]        final_indir
);
  logic [15:0] base; // displacement base
  // split the word and sign extend the displacement
  always_comb
  begin
    fields.opcode = instr[`MRAF_OP_HI:`MRAF_OP_LO];
    fields.post_x = instr[`MRAF_XBIT];
    fields.indir  = instr[`MRAF_IBIT];
    fields.pre_b  = instr[`MRAF_BBIT];
    fields.disp   = {{8{instr[`MRAF_DISP_HI]}}, instr[7:0]};
  end
  // base selection: b wins, x only when direct and no b
  always_comb
  begin
    if (fields.pre_b)
      base = b_val;
    else if (fields.post_x && !fields.indir)
      base = x_val;
    else
      base = p_val;
  end
  // sums wrap at sixteen bits, carry dropped
  always_comb
  begin
    first_addr   = 16'(base + fields.disp);
    final_direct = (fields.pre_b && fields.post_x) ? 16'(first_addr + x_val) : first_addr;
    final_indir  = fields.post_x ? 16'(ptr_val + x_val) : ptr_val;
  end
endmodule

// ### bench/mraf_mem_model.sv
// main memory model answering the block's read port
`timescale 1ns/1ps
module mraf_mem_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // read port
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_rd_addr,
  output logic             mem_rd_ack,
  output logic [15:0]      mem_rd_data,
  // wait cycles before each answer after the first since reset
  input  wire logic [1:0]  lat
);
  logic [1:0] wait_cnt; // cycles left before ack
  // content is a scramble of the full address, so no storage is needed
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return {a[6:0], a[15:7]} ^ 16'h3c5a;
  endfunction
  // one ack pulse per word; data is junk outside the ack cycle
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= 16'h0000;
      wait_cnt    <= 2'h0;
    end
    else if (mem_rd_ack)
    begin
      mem_rd_ack  <= 1'b0;
      mem_rd_data <= ~mem_rd_data; // released: no stale word left
      wait_cnt    <= lat;
    end
    else if (mem_rd_req && wait_cnt == 2'h0)
    begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= word_at(mem_rd_addr); // whole 16-bit address used
    end
    else if (mem_rd_req)
      wait_cnt <= wait_cnt - 2'h1; // slow answer
    else
      mem_rd_data <= ~mem_rd_data; // idle bus keeps changing
  end
endmodule

// ### bench/memref_address_and_operand_format_tb.sv
// self-checking bench for the memory reference address sequencer
`timescale 1ns/1ps
`include "mraf_defines.svh"
module memref_address_and_operand_format_tb;
  // bus and memory wires
  logic        clk = 1'b0; // only the clock process drives it after this
  logic        srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_rd_req, mem_rd_ack;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lat;
  logic [15:0] mem_rd_addr, mem_rd_data;
  // model state and counters
  logic [15:0] m_up, m_lo, m_ex, m_ea;
  int          miscompares, n_checks, seed;
  int          n_acks = 0; // written only by the ack counter
  mraf_core i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_req, .mem_rd_addr,
    .mem_rd_ack, .mem_rd_data);
  mraf_mem_model i_mem (.clk, .srst, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .lat);
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // count memory reads actually answered
  always @(posedge clk)
    if (mem_rd_ack === 1'b1)
      n_acks <= n_acks + 1;
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ready is sampled at the falling edge so the rising edge decision is race free
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
    int   k;
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_hs = 1'b0;
    for (k = 0; k < 64 && !b_hs; k++)
    begin
      @(negedge clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid === 1'b1;
      resp  = s_axi_bresp;
      @(posedge clk);
      if (aw_hs)
        s_axi_awvalid <= 1'b0;
      if (w_hs)
        s_axi_wvalid <= 1'b0;
      if (b_hs)
        s_axi_bready <= 1'b0;
    end
    if (!b_hs)
    begin
      miscompares++;
      report_and_stop();
    end
    else
      @(posedge clk); // bready must not drop and rise in one step
  endtask
  // read one register
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    int   k;
    logic ar_hs, r_hs;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_hs = 1'b0;
    for (k = 0; k < 64 && !r_hs; k++)
    begin
      @(negedge clk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs  = s_axi_rvalid === 1'b1;
      d     = s_axi_rdata;
      resp  = s_axi_rresp;
      @(posedge clk);
      if (ar_hs)
        s_axi_arvalid <= 1'b0;
      if (r_hs)
        s_axi_rready <= 1'b0;
    end
    if (!r_hs)
    begin
      miscompares++;
      report_and_stop();
    end
    else
      @(posedge clk); // rready must not drop and rise in one step
  endtask
  // load registers, start, wait for done and compare with the model, or check the refusal
  task automatic run_op(input logic [15:0] ins, p, b, x, input logic [1:0] fmt, input logic excl);
    logic [15:0] a;
    logic [31:0] d;
    logic [1:0]  r;
    int          n, k, acks0;
    axi_wr(32'h04, {16'h0, ins}, r);
    axi_wr(32'h08, {16'h0, p}, r);
    axi_wr(32'h0c, {16'h0, b}, r);
    axi_wr(32'h10, {16'h0, x}, r);
    a = (ins[8] ? b : (ins[10] && !ins[9] ? x : p)) + {{8{ins[7]}}, ins[7:0]};
    if (ins[9])
      a = i_mem.word_at(a);
    if (ins[10] && (ins[9] || ins[8]))
      a = a + x;
    n = (fmt == 2'h0) ? 1 : (fmt == 2'h2) ? 3 : 2;
    acks0 = n_acks;
    lat <= 2'($random(seed));
    axi_wr(32'h00, {28'h0, excl, fmt, 1'b1}, r);
    d = 32'h0;
    for (k = 0; k < 60 && d[1] !== 1'b1 && !excl; k++)
      axi_rd(32'h14, d, r);
    // a done bit that never comes is a hang, not a pass
    if (!excl && d[1] !== 1'b1)
    begin
      miscompares++;
      report_and_stop();
    end
    if (excl)
    begin
      axi_rd(32'h14, d, r);
      check({d[2], d[0], 16'(n_acks - acks0)}, 18'h20000);
      return;
    end
    m_ea = a;
    if (fmt == 2'h2)
      m_ex = i_mem.word_at(a);
    m_up = i_mem.word_at(a + 16'(fmt == 2'h2));
    if (fmt != 2'h0)
      m_lo = i_mem.word_at(16'(a + n - 1));
    axi_rd(32'h18, d, r);
    check(d, {16'h0, m_ea});
    axi_rd(32'h1c, d, r);
    check(d, {16'h0, m_up});
    axi_rd(32'h20, d, r);
    check(d, {16'h0, m_lo});
    axi_rd(32'h24, d, r);
    check(d, {16'h0, m_ex});
    check(n_acks - acks0, n + int'(ins[9]));
  endtask
  // main sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  disp;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    {lat, m_up, m_lo, m_ex, m_ea} = 66'h0;
    {miscompares, n_checks} = 64'h0;
    seed = 32'hadd1;
    srst = 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    axi_rd(32'h18, d, r);
    check(d, 32'h0);
    check(r, `MRAF_RESP_OKAY);
    axi_rd(32'h28, d, r);
    check(d, 32'h0);
    check(r, `MRAF_RESP_SLVERR);
    axi_wr(32'h14, 32'h5, r);
    check(r, `MRAF_RESP_SLVERR);
    for (int i = 0; i < 28; i++)
    begin
      disp = (i < 8) ? 8'h80 : (i < 16) ? 8'h7f : 8'($random(seed));
      run_op({5'($random(seed)), 3'(i), disp}, (i == 3) ? 16'hffff : 16'($random(seed)),
             16'($random(seed)), 16'($random(seed)), 2'(i) ^ 2'(i >> 2), 1'b0);
    end
    run_op(16'h0701, 16'h1234, 16'h0, 16'h0, 2'h1, 1'b1);
    axi_rd(32'h18, d, r);
    check(d, {16'h0, m_ea});
    report_and_stop();
  end
endmodule
